// File: verilog/dcp_pkg.sv
// Shared constants and types for the DMA channel progress block.
// Assumes one 200 MHz clock and an APB slave port with 32-bit data.
package dcp_pkg;

  // Register byte offsets on the APB port
  localparam logic [7:0] OFS_DEST_IDX  = 8'h00;
  localparam logic [7:0] OFS_CELL_LEN  = 8'h04;
  localparam logic [7:0] OFS_CELL_PROG = 8'h08;
  localparam logic [7:0] OFS_MATCH     = 8'h0c;
  localparam logic [7:0] OFS_CTRL      = 8'h10;
  localparam logic [7:0] OFS_DEST_LEN  = 8'h14;
  localparam logic [7:0] OFS_STATUS    = 8'h18;

  // Field positions
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_PAT_BIT   = 1;
  localparam int unsigned STAT_CELL_BIT  = 0;
  localparam int unsigned STAT_BLOCK_BIT = 1;
  localparam int unsigned STAT_MATCH_BIT = 2;
  localparam int unsigned STAT_BUSY_BIT  = 3;

  // Values after reset
  localparam logic [15:0] RST_LEN16 = 16'h0000;
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [1:0]  RST_CTRL  = 2'h0;

  // A zero length field stands for a full 64 KiB
  localparam logic [16:0] FULL_LEN = 17'h10000;

  // Buffer shape
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned FIFO_DEPTH = 8;

  // Channel states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_MOVE
  } dcp_state_t;

  // One byte handed to the destination
  typedef struct packed {
    logic [15:0] index;
    logic [7:0]  data;
    logic        match;
  } dcp_beat_t;

endpackage

// File: verilog/dcp_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock, synchronous active-low reset and a clock enable.
module dcp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             rdy_q;
  logic             vld_q;
  wire              push = in_valid & rdy_q;
  wire              pop  = out_ready & vld_q;

  // Flags are registered so the top-level ready comes from a flop
  assign cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready  = rdy_q;
  assign out_valid = vld_q;
  assign out_data  = mem[rd_ptr_q];

  // Pointers wrap at DEPTH, which need not be a power of two
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
      rdy_q    <= 1'b0;
      vld_q    <= 1'b0;
    end
    else if (ce)
    begin
      if (push)
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      if (pop)
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      cnt_q <= cnt_d;
      rdy_q <= cnt_d != (AW+1)'(DEPTH);
      vld_q <= cnt_d != '0;
    end
  end

  // Storage holds no reset; valid guards every read
  always_ff @(posedge clock)
  begin
    if (ce && push)
      mem[wr_ptr_q] <= in_data;
  end

endmodule

// File: verilog/dcp_channel.sv
// One DMA channel's progress tracking and pattern match, APB registers.
// Assumes a byte source with valid/ready and a destination with ready.
//
// Summary of operation
// - Read-only 16-bit destination byte index
// - Upper 16 bits of pointer registers read zero
// - Cell length zero moves 65,536 bytes
// - Nonzero cell length N moves N bytes
// - Progress counts bytes since last trigger; cell end clears it
// - Pattern match clears cell progress
// - Match byte ignored outside pattern mode
// - Match register upper 24 bits read zero
// - Reset clears index, length, progress, match
// - Destination length zero means 65,536 bytes
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
module dcp_channel (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cell_trigger,
  input  wire logic        src_valid,
  output logic             src_ready,
  input  wire logic [7:0]  src_data,
  output logic             dst_valid,
  input  wire logic        dst_ready,
  output dcp_pkg::dcp_beat_t dst_beat,
  output logic             cell_busy
);

  dcp_pkg::dcp_state_t state_q;
  dcp_pkg::dcp_state_t state_d;
  dcp_pkg::dcp_beat_t  beat_q;
  logic [15:0] dest_byte_index_q;
  logic [15:0] cell_length_q;
  logic [15:0] cell_progress_q;
  logic [7:0]  match_byte_q;
  logic [15:0] dest_block_length_q;
  logic [1:0]  ctrl_q;
  logic        cell_done_q;
  logic        block_done_q;
  logic        match_hit_q;
  logic        busy_q;
  logic        dst_valid_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic        fifo_valid;
  logic [7:0]  fifo_data;

  // APB decode; writes land on the completing access edge
  wire        setup_rd = psel & penable & ~pready_q;
  wire        acc      = psel & penable & pready_q;
  wire        wr_acc   = acc & pwrite;
  wire        sel_idx  = paddr == dcp_pkg::OFS_DEST_IDX;
  wire        sel_clen = paddr == dcp_pkg::OFS_CELL_LEN;
  wire        sel_prog = paddr == dcp_pkg::OFS_CELL_PROG;
  wire        sel_mat  = paddr == dcp_pkg::OFS_MATCH;
  wire        sel_ctrl = paddr == dcp_pkg::OFS_CTRL;
  wire        sel_dlen = paddr == dcp_pkg::OFS_DEST_LEN;
  wire        sel_stat = paddr == dcp_pkg::OFS_STATUS;
  wire        hit      = sel_idx | sel_clen | sel_prog | sel_mat |
                         sel_ctrl | sel_dlen | sel_stat;
  wire [31:0] stat_rd  = {28'h0000000, busy_q, match_hit_q,
                          block_done_q, cell_done_q};

  // Read mux; unimplemented upper bits stay zero
  wire [31:0] rd_mux =
    sel_idx  ? {16'h0000, dest_byte_index_q}   :
    sel_clen ? {16'h0000, cell_length_q}       :
    sel_prog ? {16'h0000, cell_progress_q}     :
    sel_mat  ? {24'h000000, match_byte_q}      :
    sel_ctrl ? {30'h0, ctrl_q}                 :
    sel_dlen ? {16'h0000, dest_block_length_q} :
    sel_stat ? stat_rd                         :
               32'h00000000;

  // Zero length fields stand for the full 64 KiB
  wire [16:0] cell_len_eff = (cell_length_q == 16'h0000) ?
                             dcp_pkg::FULL_LEN : {1'b0, cell_length_q};
  wire [16:0] dest_len_eff = (dest_block_length_q == 16'h0000) ?
                             dcp_pkg::FULL_LEN :
                             {1'b0, dest_block_length_q};
  wire [16:0] prog_next    = {1'b0, cell_progress_q} + 17'h00001;
  wire [16:0] idx_next     = {1'b0, dest_byte_index_q} + 17'h00001;
  wire        cell_last    = prog_next == cell_len_eff;
  wire        dest_last    = idx_next == dest_len_eff;

  // A byte leaves the buffer only inside a live cell
  wire        moving    = state_q == dcp_pkg::ST_MOVE;
  wire        load      = fifo_valid & moving & (~dst_valid_q | dst_ready);
  wire        pat_mode  = ctrl_q[dcp_pkg::CTRL_PAT_BIT];
  wire        is_match  = pat_mode & (fifo_data == match_byte_q);
  wire        hw_stop   = load & (is_match | dest_last);
  wire        start     = (state_q == dcp_pkg::ST_WAIT) & cell_trigger &
                          ctrl_q[dcp_pkg::CTRL_EN_BIT];
  wire        stat_wr   = wr_acc & sel_stat;

  // Byte buffer between source and destination register
  dcp_fifo #(
    .WIDTH (dcp_pkg::BYTE_W),
    .DEPTH (dcp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst_b     (rst_b),
    .ce        (ce),
    .in_valid  (src_valid),
    .in_ready  (src_ready),
    .in_data   (src_data),
    .out_valid (fifo_valid),
    .out_ready (load),
    .out_data  (fifo_data)
  );

  // Channel sequencing: trigger opens a cell, last byte closes it
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      dcp_pkg::ST_IDLE:
        if (ctrl_q[dcp_pkg::CTRL_EN_BIT])
          state_d = dcp_pkg::ST_WAIT;
      dcp_pkg::ST_WAIT:
        if (!ctrl_q[dcp_pkg::CTRL_EN_BIT])
          state_d = dcp_pkg::ST_IDLE;
        else if (cell_trigger)
          state_d = dcp_pkg::ST_MOVE;
      dcp_pkg::ST_MOVE:
        if (!ctrl_q[dcp_pkg::CTRL_EN_BIT] || hw_stop)
          state_d = dcp_pkg::ST_IDLE;
        else if (load && cell_last)
          state_d = dcp_pkg::ST_WAIT;
      default:
        state_d = dcp_pkg::ST_IDLE;
    endcase
  end

  // APB answer: one wait state, then pready for one cycle
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end
    else if (ce)
    begin
      pready_q  <= setup_rd;
      pslverr_q <= setup_rd & ~hit;
      if (setup_rd && !pwrite)
        prdata_q <= rd_mux;
    end
  end

  // Software-owned fields; a match or block end drops the enable
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      cell_length_q       <= dcp_pkg::RST_LEN16;
      match_byte_q        <= dcp_pkg::RST_BYTE;
      dest_block_length_q <= dcp_pkg::RST_LEN16;
      ctrl_q              <= dcp_pkg::RST_CTRL;
    end
    else if (ce)
    begin
      if (wr_acc && sel_clen)
        cell_length_q <= pwdata[15:0];
      if (wr_acc && sel_mat)
        match_byte_q <= pwdata[7:0];
      if (wr_acc && sel_dlen)
        dest_block_length_q <= pwdata[15:0];
      if (hw_stop)
        ctrl_q[dcp_pkg::CTRL_EN_BIT] <= 1'b0;
      else if (wr_acc && sel_ctrl)
        ctrl_q[dcp_pkg::CTRL_EN_BIT] <= pwdata[dcp_pkg::CTRL_EN_BIT];
      if (wr_acc && sel_ctrl)
        ctrl_q[dcp_pkg::CTRL_PAT_BIT] <= pwdata[dcp_pkg::CTRL_PAT_BIT];
    end
  end

  // Progress counters advance once per byte committed
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      dest_byte_index_q <= dcp_pkg::RST_LEN16;
      cell_progress_q   <= dcp_pkg::RST_LEN16;
    end
    else if (ce)
    begin
      if (load)
        dest_byte_index_q <= dest_last ? 16'h0000 : idx_next[15:0];
      if (start)
        cell_progress_q <= 16'h0000;
      else if (load && (cell_last || is_match))
        cell_progress_q <= 16'h0000;
      else if (load)
        cell_progress_q <= prog_next[15:0];
    end
  end

  // Sticky done and match bits, write one to clear; a new event wins the clear; busy follows the next state
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      cell_done_q  <= 1'b0;
      block_done_q <= 1'b0;
      match_hit_q  <= 1'b0;
      busy_q       <= 1'b0;
    end
    else if (ce)
    begin
      cell_done_q  <= (load & cell_last) |
        (cell_done_q & ~(stat_wr & pwdata[dcp_pkg::STAT_CELL_BIT]));
      block_done_q <= (load & dest_last) |
        (block_done_q & ~(stat_wr & pwdata[dcp_pkg::STAT_BLOCK_BIT]));
      match_hit_q  <= (load & is_match) |
        (match_hit_q & ~(stat_wr & pwdata[dcp_pkg::STAT_MATCH_BIT]));
      busy_q       <= state_d == dcp_pkg::ST_MOVE;
    end
  end

  // State and destination register; the beat holds until accepted
  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      state_q     <= dcp_pkg::ST_IDLE;
      dst_valid_q <= 1'b0;
      beat_q      <= '0;
    end
    else if (ce)
    begin
      state_q <= state_d;
      if (load)
      begin
        dst_valid_q <= 1'b1;
        beat_q      <= '{index: dest_byte_index_q, data: fifo_data,
                         match: is_match};
      end
      else if (dst_ready)
        dst_valid_q <= 1'b0;
    end
  end

  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign dst_valid = dst_valid_q;
  assign dst_beat  = beat_q;
  assign cell_busy = busy_q;

  // Checks on the channel behaviour
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  sequence s_match_end;
    cell_progress_q == 16'h0000 ##0 state_q == dcp_pkg::ST_IDLE;
  endsequence

  property p_idx_step;
    ce && load && !dest_last |=>
      dest_byte_index_q == 16'($past(dest_byte_index_q) + 16'h0001);
  endproperty
  a_idx_step: assert property (p_idx_step)
    else $error("index did not advance by one");

  property p_upper_zero;
    ce && setup_rd && !pwrite && (sel_idx || sel_clen || sel_prog) |=>
      pready_q && prdata_q[31:16] == 16'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper pointer bits not zero");

  property p_full_cell;
    ce && load && cell_last && cell_length_q == 16'h0000 |->
      cell_progress_q == 16'hffff;
  endproperty
  a_full_cell: assert property (p_full_cell)
    else $error("zero length cell ended early");

  property p_n_cell;
    ce && load && cell_last && cell_length_q != 16'h0000 |->
      16'(cell_progress_q + 16'h0001) == cell_length_q ##1
      cell_progress_q == 16'h0000;
  endproperty
  a_n_cell: assert property (p_n_cell)
    else $error("cell length not honoured");

  property p_trig_zero;
    ce && start |=> cell_progress_q == 16'h0000 &&
      state_q == dcp_pkg::ST_MOVE;
  endproperty
  a_trig_zero: assert property (p_trig_zero)
    else $error("progress not cleared on trigger");

  property p_match_clr;
    ce && load && is_match |=> s_match_end ##0 match_hit_q;
  endproperty
  a_match_clr: assert property (p_match_clr)
    else $error("match did not clear progress");

  property p_match_ignored;
    ce && load && !pat_mode && !cell_last && !dest_last &&
      ctrl_q[dcp_pkg::CTRL_EN_BIT] |=>
      state_q == dcp_pkg::ST_MOVE &&
      cell_progress_q == 16'($past(cell_progress_q) + 16'h0001);
  endproperty
  a_match_ignored: assert property (p_match_ignored)
    else $error("match byte acted outside pattern mode");

  property p_match_upper;
    ce && setup_rd && !pwrite && sel_mat |=> prdata_q[31:8] == 24'h000000;
  endproperty
  a_match_upper: assert property (p_match_upper)
    else $error("match register upper bits not zero");

  property p_reset;
    disable iff (1'b0)
    !rst_b |=> dest_byte_index_q == 16'h0000 &&
      cell_length_q == 16'h0000 && cell_progress_q == 16'h0000 &&
      match_byte_q == 8'h00;
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset left a field nonzero");

  property p_block_wrap;
    ce && load && dest_last |=> dest_byte_index_q == 16'h0000 &&
      block_done_q && !ctrl_q[dcp_pkg::CTRL_EN_BIT];
  endproperty
  a_block_wrap: assert property (p_block_wrap)
    else $error("block end not handled");

endmodule

// File: test/dcp_far_end.sv
// Far-side model: byte source feeding the channel, byte sink draining it.
// Assumes the bench queues source bytes and drives the stall input.
module dcp_far_end (
  input  wire logic               clock,
  input  wire logic               rst_b,
  input  wire logic               ce,
  input  wire logic               stall,
  output logic                    src_valid = 1'b0,
  input  wire logic               src_ready,
  output logic [7:0]              src_data = 8'h00,
  input  wire logic               dst_valid,
  output logic                    dst_ready = 1'b0,
  input  wire dcp_pkg::dcp_beat_t dst_beat
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]         src_q[$];
  dcp_pkg::dcp_beat_t got_q[$];

  task load(input logic [7:0] b);
    src_q.push_back(b);
  endtask

  // Offer holds until taken; idle data toggles so stale bytes never match
  always @(posedge clock)
  begin
    // A frozen channel takes no byte, so the offer must stand
    if (ce && src_valid && src_ready)
      void'(src_q.pop_front());
    if (!rst_b || src_q.size() == 0)
    begin
      src_valid <= 1'b0;
      src_data  <= ~src_data;
    end
    else
    begin
      src_valid <= 1'b1;
      src_data  <= src_q[0];
    end
  end

  // Sink stalls at random, records every accepted beat
  always @(posedge clock)
  begin
    dst_ready <= rst_b & ~stall;
    if (ce && dst_valid && dst_ready)
      got_q.push_back(dst_beat);
  end
endmodule

// File: test/dcp_channel_tb.sv
// Bench for the channel progress block: APB master, model and far end.
// Assumes the package offsets and a one-wait-state APB slave.
module dcp_channel_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic               clock = 1'b0;
  logic               rst_b = 1'b0;
  logic               ce = 1'b1;
  time                t0;
  logic               psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0, prdata;
  logic               pready, pslverr, cell_trigger = 1'b0, stall = 1'b0;
  logic               src_valid, src_ready, dst_valid, dst_ready, cell_busy;
  logic [7:0]         src_data, m;
  dcp_pkg::dcp_beat_t dst_beat, exp_q[$];
  logic [31:0]        rd;
  logic               err;
  int                 miscompares = 0, n_compared = 0, di = 0;
  int                 seed = 32'h4ed0dccd;
  logic [7:0]         b[8];

  dcp_channel u_dcp_channel (.clock, .rst_b, .ce, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cell_trigger,
    .src_valid, .src_ready, .src_data, .dst_valid, .dst_ready, .dst_beat,
    .cell_busy);
  dcp_far_end u_dcp_far_end (.clock, .rst_b, .ce, .stall, .src_valid,
    .src_ready, .src_data, .dst_valid, .dst_ready, .dst_beat);

  // Clock and random sink back-pressure
  always #2.5 clock = ~clock;
  always @(posedge clock)
    stall <= ($random(seed) & 3) == 0;

  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR t=%0t got %h expected %h", $time, g, e);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 40);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 40)
      chk(32'h1, 32'h0);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // Model side: byte enters the far end and the expected beat queue
  task send(input logic [7:0] x, input logic hit);
    u_dcp_far_end.load(x);
    exp_q.push_back('{index: di[15:0], data: x, match: hit});
    di++;
  endtask

  task trig;
    @(posedge clock);
    cell_trigger <= 1'b1;
    repeat (2) @(posedge clock);
    cell_trigger <= 1'b0;
  endtask

  // Bounded wait for the expected beats, then compare in order
  task beats;
    int n;
    n = 0;
    while (u_dcp_far_end.got_q.size() < exp_q.size() && n < 500)
    begin
      @(posedge clock);
      n++;
    end
    while (exp_q.size() > 0)
      if (u_dcp_far_end.got_q.size() > 0)
        chk({7'h0, u_dcp_far_end.got_q.pop_front()}, {7'h0, exp_q.pop_front()});
      else
        chk({7'h0, 25'h1ffffff}, {7'h0, exp_q.pop_front()});
  endtask

  initial
  begin
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    rdc(dcp_pkg::OFS_DEST_IDX, 32'h0);
    rdc(dcp_pkg::OFS_CELL_LEN, 32'h0);
    rdc(dcp_pkg::OFS_CELL_PROG, 32'h0);
    rdc(dcp_pkg::OFS_MATCH, 32'h0);
    apb(1'b1, dcp_pkg::OFS_CELL_LEN, 32'hffff_0005);
    rdc(dcp_pkg::OFS_CELL_LEN, 32'h0000_0005);
    apb(1'b1, dcp_pkg::OFS_DEST_IDX, 32'hffff_1234);
    rdc(dcp_pkg::OFS_DEST_IDX, 32'h0);
    apb(1'b1, dcp_pkg::OFS_MATCH, 32'hffff_ff5a);
    rdc(dcp_pkg::OFS_MATCH, 32'h0000_005a);
    apb(1'b1, 8'h1c, 32'hffff_ffff);
    chk({31'h0, err}, 32'h1);
    rdc(8'h1c, 32'h0);
    // Fill the buffer while the channel is idle
    for (int i = 0; i < 8; i++)
    begin
      b[i] = 8'($random(seed));
      send(b[i], 1'b0);
    end
    repeat (14) @(posedge clock);
    chk({31'h0, src_ready}, 32'h0);
    chk({31'h0, dst_valid}, 32'h0);
    chk({31'h0, cell_busy}, 32'h0);
    apb(1'b1, dcp_pkg::OFS_MATCH, {24'h0, b[2]});
    apb(1'b1, dcp_pkg::OFS_CTRL, 32'h1);
    trig;
    repeat (3) exp_q.pop_back();
    di = 5;
    beats;
    rdc(dcp_pkg::OFS_CELL_PROG, 32'h0);
    rdc(dcp_pkg::OFS_DEST_IDX, 32'h5);
    for (int i = 5; i < 8; i++)
      exp_q.push_back('{index: 16'(i), data: b[i], match: 1'b0});
    di = 8;
    trig;
    beats;
    chk({31'h0, cell_busy}, 32'h1);
    rdc(dcp_pkg::OFS_CELL_PROG, 32'h3);
    rdc(dcp_pkg::OFS_DEST_IDX, 32'h8);
    m = 8'($random(seed));
    apb(1'b1, dcp_pkg::OFS_MATCH, {24'h0, m});
    apb(1'b1, dcp_pkg::OFS_CTRL, 32'h3);
    send(m, 1'b1);
    beats;
    rdc(dcp_pkg::OFS_CELL_PROG, 32'h0);
    // Clock enable low stalls the answer; the read must still land
    t0 = $time;
    fork
      rdc(dcp_pkg::OFS_DEST_IDX, 32'h9);
      begin
        ce <= 1'b0;
        repeat (6) @(posedge clock);
        ce <= 1'b1;
      end
    join
    chk({31'h0, ($time - t0) > 35}, 32'h1);
    rdc(dcp_pkg::OFS_CTRL, 32'h2);
    apb(1'b1, dcp_pkg::OFS_CELL_LEN, 32'h0);
    apb(1'b1, dcp_pkg::OFS_CTRL, 32'h1);
    trig;
    repeat (3) send(8'($random(seed)), 1'b0);
    beats;
    rdc(dcp_pkg::OFS_CELL_PROG, 32'h3);
    rdc(dcp_pkg::OFS_DEST_IDX, 32'hc);
    // Block end at index 13 wraps the index and drops the enable
    apb(1'b1, dcp_pkg::OFS_DEST_LEN, 32'he);
    repeat (2) send(8'($random(seed)), 1'b0);
    beats;
    rdc(dcp_pkg::OFS_DEST_IDX, 32'h0);
    rdc(dcp_pkg::OFS_CTRL, 32'h0);
    rdc(dcp_pkg::OFS_STATUS, 32'h7);
    apb(1'b1, dcp_pkg::OFS_STATUS, 32'h7);
    rdc(dcp_pkg::OFS_STATUS, 32'h0);
    wrap_up;
  end

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clock);
    miscompares++;
    wrap_up;
  end
endmodule
